// [verilog/ctf_pkg.sv]
// constants and carrier types for the chronograph timing controller
package ctf_pkg;
  // clock and time figures
  localparam longint CLK_HZ = 25_000_000;
  localparam longint HOLD_MS = 2_000;
  localparam logic [31:0] HOLD_CYC = 32'(HOLD_MS * (CLK_HZ / 1000));
  localparam logic [31:0] INIT_CYC = 32'd50_331_648;
  localparam logic [31:0] BLANK_CYC = 32'd3_221_225_472;
  localparam logic [23:0] ELAPSED_MAX = 24'hffffff;
  // speed arithmetic
  localparam longint SPACING_MM = 300;
  localparam longint SPEED_MAX_DM = 15010;
  localparam longint DIST_SCALE = 10;
  localparam logic [13:0] SPEED_SAT = 14'h3fff;
  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_SPEED = 4'h8;
  localparam logic [3:0] ADDR_ELAPSED = 4'hc;
  // field positions
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_BLANK_BIT = 1;
  localparam int STAT_BLANK_BIT = 7;
  localparam int STAT_ABANDON_BIT = 8;
  localparam logic CTRL_ARM_RST = 1'b1;
  // display scan and segment codes (a f b g c d e dp)
  localparam int SCAN_DIV = 25_000;
  localparam logic [7:0] SEG_DASH = 8'h10;
  localparam logic [7:0] SEG_DP = 8'h01;
  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [6:0] {
    CTF_INIT = 7'h01,
    CTF_IDLE = 7'h02,
    CTF_WAIT_STOP = 7'h04,
    CTF_CHECK = 7'h08,
    CTF_CALC = 7'h10,
    CTF_CONV = 7'h20,
    CTF_HOLD = 7'h40
  } ctf_state_t;

  // decimal digits coming back from the converter
  typedef struct packed {
    logic top_decimal_digit;
    logic [3:0] thousands;
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] ones;
  } ctf_bcd_t;

  // fixed control levels toward oscillator and sensor pins
  typedef struct packed {
    logic osc_rate_sel;
    logic osc_enable;
    logic start_dir;
    logic stop_dir;
  } ctf_pins_t;
endpackage

// [verilog/ctf_display.sv]
// four-digit multiplexed seven-segment scanner with dash blanking
`timescale 1ns/1ps
module ctf_display
  import ctf_pkg::*;
#(
  parameter int DIV = SCAN_DIV
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic blank,
  input ctf_bcd_t digits,
  output logic [7:0] segments,
  output logic [3:0] digit_sel_n
);
  if (DIV < 2) begin : g_chk
    $error("ctf_display: DIV must be at least 2");
  end

  logic [31:0] div_reg, div_next;
  logic [1:0] pos_reg, pos_next;
  logic [7:0] seg_reg, seg_next;
  logic [3:0] sel_reg, sel_next;
  logic [3:0] nib;
  logic dp;

  function automatic logic [7:0] seg_of(input logic [3:0] v);
    unique case (v)
      4'h0: seg_of = 8'he6;
      4'h1: seg_of = 8'h28;
      4'h2: seg_of = 8'hb6;
      4'h3: seg_of = 8'hbc;
      4'h4: seg_of = 8'h78;
      4'h5: seg_of = 8'hdc;
      4'h6: seg_of = 8'hde;
      4'h7: seg_of = 8'ha8;
      4'h8: seg_of = 8'hfe;
      4'h9: seg_of = 8'hfc;
      default: seg_of = SEG_DASH;
    endcase
  endfunction

  // pick digit for the next position (pos_next); bit 3 is the leftmost digit
  always_comb
  begin
    div_next = (div_reg == 32'(DIV - 1)) ? 32'h0 : div_reg + 32'h1;
    pos_next = (div_reg == 32'(DIV - 1)) ? pos_reg + 2'h1 : pos_reg;
    nib = 4'h0;
    dp = 1'b0;
    if (!digits.top_decimal_digit)
    begin
      // 0.1 m/s resolution: point sits left of the tenths digit
      unique case (pos_next)
        2'd3: nib = digits.thousands;
        2'd2: nib = digits.hundreds;
        2'd1: nib = digits.tens;
        default: nib = digits.ones;
      endcase
      dp = (pos_next == 2'd1);
    end
    else
    begin
      // whole metres per second, tenths dropped
      unique case (pos_next)
        2'd3: nib = {3'h0, digits.top_decimal_digit};
        2'd2: nib = digits.thousands;
        2'd1: nib = digits.hundreds;
        default: nib = digits.tens;
      endcase
    end
    seg_next = blank ? SEG_DASH : (seg_of(nib) | (dp ? SEG_DP : 8'h0));
    sel_next = ~(4'h1 << pos_next);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_reg <= 32'h0;
      pos_reg <= 2'h0;
      seg_reg <= 8'h0;
      sel_reg <= 4'hf;
    end
    else
    begin
      div_reg <= div_next;
      pos_reg <= pos_next;
      seg_reg <= seg_next;
      sel_reg <= sel_next;
    end
  end

  assign segments = seg_reg;
  assign digit_sel_n = sel_reg;
endmodule

// [verilog/ctf_top.sv]
// chronograph timing controller with ahb-lite status and control
// Notes on behaviour
// - oscillator rate select output is held high for the fast rate.
// - oscillator enable and both sensor direction outputs stay high.
// - after reset is released the machine starts in initialisation.
// - initialisation waits 50,331,648 cycles for sensors, then goes idle.
// - idle clears the elapsed count, reloads distance and waits for the first sensor.
// - idle with display shown counts 3,221,225,472 cycles then blanks.
// - waiting for second sensor counts cycles; its edge goes to check.
// - no second sensor within 16,777,216 cycles abandons back to idle.
// - count below minimum flight ticks is forced to 0xffffff.
// - speed is number of subtractions of count from distance.
// - conversion pulses convert enable, unblanks display, goes to hold-off.
// - hold-off waits two seconds before returning to idle.
// - distance equals spacing in millimetres times frequency times ten, divided by 1000.
// - minimum flight ticks equals distance divided by 15010.
// - digit select bit 3 is the most significant digit.
// - speed leaves as a 14-bit binary value for the converter.
// - display shows four dashes while blank flag is high.
// - top digit zero shows lower four digits, else upper four.
`timescale 1ns/1ps
module ctf_top
  import ctf_pkg::*;
#(
  parameter logic [31:0] INIT_TICKS = INIT_CYC,
  parameter logic [31:0] BLANK_TICKS = BLANK_CYC,
  parameter logic [31:0] HOLD_TICKS = HOLD_CYC,
  parameter longint OSC_HZ = CLK_HZ,
  parameter longint SPACE_MM = SPACING_MM,
  parameter int SCAN_TICKS = SCAN_DIV,
  parameter logic [23:0] STOP_LIMIT = ELAPSED_MAX
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic start_in,
  input wire logic stop_in,
  input ctf_bcd_t bcd_digits,
  output ctf_pins_t pin_ctrl,
  output logic [13:0] speed_binary,
  output logic convert_en,
  output logic display_blank,
  output logic [7:0] segments,
  output logic [3:0] digit_sel_n
);
  // distance and fastest-flight figures from spacing and clock
  localparam longint DIST_L = (OSC_HZ * SPACE_MM * DIST_SCALE) / 1000;
  localparam logic [31:0] DISTANCE = 32'(DIST_L);
  localparam logic [23:0] MIN_TICKS = 24'(DIST_L / SPEED_MAX_DM);

  // a zero minimum flight time would let a zero count spin the divider
  if (DIST_L < SPEED_MAX_DM || DIST_L > 64'hffffffff ||
      INIT_TICKS == 32'h0 || BLANK_TICKS == 32'h0 || HOLD_TICKS == 32'h0 ||
      STOP_LIMIT == 24'h0) begin : g_chk
    $error("ctf_top: parameters out of range");
  end

  // three-stage synchronisers; edge counted once stages 2 and 3 agree
  logic [1:0] raw;
  logic [1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next, rise;
  assign raw = {stop_in, start_in};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_comb
    begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
      rise[i] = lvl_next[i] & ~lvl_reg[i];
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        s1_reg[i] <= 1'b0;
        s2_reg[i] <= 1'b0;
        s3_reg[i] <= 1'b0;
        lvl_reg[i] <= 1'b0;
      end
      else
      begin
        s1_reg[i] <= raw[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        lvl_reg[i] <= lvl_next[i];
      end
    end
  end

  // measurement state
  ctf_state_t st_reg, st_next;
  logic [31:0] timer_reg, timer_next;
  logic [23:0] elapsed_reg, elapsed_next;
  logic [31:0] rem_reg, rem_next;
  logic [13:0] speed_reg, speed_next;
  logic conv_reg, conv_next;
  logic blank_reg, blank_next;
  logic abandon_reg, abandon_next;
  // bus-side state
  logic arm_reg, arm_next;
  logic wr_pend_reg, wr_pend_next;
  logic [3:0] wa_reg, wa_next;
  logic [31:0] rdata_reg, rdata_next;
  logic blank_req, abandon_clr, addr_ok;
  logic ahb_write;

  // fsm next-state logic
  always_comb
  begin
    st_next = st_reg;
    timer_next = timer_reg;
    elapsed_next = elapsed_reg;
    rem_next = rem_reg;
    speed_next = speed_reg;
    conv_next = 1'b0;
    blank_next = blank_reg | blank_req;
    abandon_next = abandon_reg & ~abandon_clr;
    unique case (st_reg)
      CTF_INIT:
      begin
        // sensors need settling time after power-up
        timer_next = timer_reg + 32'h1;
        if (timer_reg == INIT_TICKS - 32'h1)
        begin
          timer_next = 32'h0;
          st_next = CTF_IDLE;
        end
      end
      CTF_IDLE:
      begin
        elapsed_next = 24'h0;
        rem_next = DISTANCE;
        // result stays visible for a while, then dashes
        if (!blank_reg)
        begin
          timer_next = timer_reg + 32'h1;
          if (timer_reg == BLANK_TICKS - 32'h1)
          begin
            timer_next = 32'h0;
            blank_next = 1'b1;
          end
        end
        else
          timer_next = 32'h0;
        if (rise[0] && arm_reg)
        begin
          timer_next = 32'h0;
          st_next = CTF_WAIT_STOP;
        end
      end
      CTF_WAIT_STOP:
      begin
        elapsed_next = elapsed_reg + 24'h1;
        if (rise[1])
        begin
          elapsed_next = elapsed_reg;
          st_next = CTF_CHECK;
        end
        else if (elapsed_reg == STOP_LIMIT)
        begin
          // too slow to measure, drop it
          abandon_next = 1'b1;
          st_next = CTF_IDLE;
        end
      end
      CTF_CHECK:
      begin
        // faster than the top speed: treat as nonsense time
        if (elapsed_reg < MIN_TICKS)
          elapsed_next = ELAPSED_MAX;
        speed_next = 14'h0;
        st_next = CTF_CALC;
      end
      CTF_CALC:
      begin
        // one subtraction per cycle avoids a wide divider
        if (rem_reg >= {8'h0, elapsed_reg})
        begin
          rem_next = rem_reg - {8'h0, elapsed_reg};
          if (speed_reg != SPEED_SAT)
            speed_next = speed_reg + 14'h1;
        end
        else
        begin
          conv_next = 1'b1;
          st_next = CTF_CONV;
        end
      end
      CTF_CONV:
      begin
        blank_next = 1'b0;
        timer_next = 32'h0;
        st_next = CTF_HOLD;
      end
      CTF_HOLD:
      begin
        // ignore muzzle gas and shock wave after the shot
        timer_next = timer_reg + 32'h1;
        if (timer_reg == HOLD_TICKS - 32'h1)
        begin
          timer_next = 32'h0;
          st_next = CTF_IDLE;
        end
      end
      default:
        st_next = CTF_INIT;
    endcase
  end

  // reset lands in initialisation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= CTF_INIT;
      timer_reg <= 32'h0;
      elapsed_reg <= 24'h0;
      rem_reg <= 32'h0;
      speed_reg <= 14'h0;
      conv_reg <= 1'b0;
      blank_reg <= 1'b1;
      abandon_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      timer_reg <= timer_next;
      elapsed_reg <= elapsed_next;
      rem_reg <= rem_next;
      speed_reg <= speed_next;
      conv_reg <= conv_next;
      blank_reg <= blank_next;
      abandon_reg <= abandon_next;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  always_comb
  begin
    ahb_write = wr_pend_reg;
    addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    // offsets outside the map must not alias onto the registers
    wr_pend_next = addr_ok && hwrite && haddr[31:4] == 28'h0;
    wa_next = addr_ok ? haddr[3:0] : wa_reg;
    arm_next = arm_reg;
    blank_req = 1'b0;
    abandon_clr = 1'b0;
    if (ahb_write && wa_reg == ADDR_CTRL)
    begin
      arm_next = hwdata[CTRL_ARM_BIT];
      blank_req = hwdata[CTRL_BLANK_BIT];
    end
    // write one clears; a new abandon in the same cycle still wins
    if (ahb_write && wa_reg == ADDR_STATUS)
      abandon_clr = hwdata[STAT_ABANDON_BIT];
    rdata_next = 32'h0;
    if (addr_ok && !hwrite && haddr[31:4] == 28'h0)
    begin
      unique case (haddr[3:0])
        ADDR_CTRL: rdata_next = {30'h0, 1'b0, arm_reg};
        ADDR_STATUS: rdata_next = {23'h0, abandon_reg, blank_reg, st_reg};
        ADDR_SPEED: rdata_next = {18'h0, speed_reg};
        ADDR_ELAPSED: rdata_next = {8'h0, elapsed_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arm_reg <= CTRL_ARM_RST;
      wr_pend_reg <= 1'b0;
      wa_reg <= 4'h0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      arm_reg <= arm_next;
      wr_pend_reg <= wr_pend_next;
      wa_reg <= wa_next;
      rdata_reg <= rdata_next;
    end
  end

  // fixed pin levels, still registered so outputs come from flops
  ctf_pins_t pins_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pins_reg <= '{1'b1, 1'b1, 1'b1, 1'b1};
    else
      pins_reg <= '{1'b1, 1'b1, 1'b1, 1'b1};
  end

  ctf_display #(.DIV(SCAN_TICKS)) i_ctf_display (
    .hclk(hclk),
    .hresetn(hresetn),
    .blank(blank_reg),
    .digits(bcd_digits),
    .segments(segments),
    .digit_sel_n(digit_sel_n)
  );

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pin_ctrl = pins_reg;
  assign speed_binary = speed_reg;
  assign convert_en = conv_reg;
  assign display_blank = blank_reg;
endmodule

// [test/ctf_top_assertions.sv]
// port-level property checker for the chronograph controller
`timescale 1ns/1ps
module ctf_top_assertions
  import ctf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ctf_pins_t pin_ctrl,
  input wire logic [13:0] speed_binary,
  input wire logic convert_en,
  input wire logic display_blank,
  input wire logic [7:0] segments,
  input wire logic [3:0] digit_sel_n
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // fixed levels toward oscillator and sensor pins
  pins_fixed_a: assert property (pin_ctrl == 4'hf)
    else $error("pin control not all high");
  reset_view_a: assert property ($rose(hresetn) |-> display_blank)
    else $error("not blank after reset release");
  conv_pulse_a: assert property (convert_en |=> !convert_en)
    else $error("convert enable longer than one cycle");
  display_shown_a: assert property (convert_en |=> !display_blank)
    else $error("display not shown after convert");
  blank_cause_a: assert property (
    $fell(display_blank) |-> $past(convert_en))
    else $error("display shown without convert");
  // result must stay up for the first eight cycles of hold-off
  hold_show_a: assert property (
    convert_en |=> !display_blank[*8])
    else $error("result blanked during hold-off");
  speed_held_a: assert property (
    convert_en |=> $stable(speed_binary)[*8])
    else $error("speed changed after convert");
  dash_shown_a: assert property (
    display_blank[*4] ##0 !(&digit_sel_n) |-> segments == SEG_DASH)
    else $error("blank display not showing dashes");
  one_digit_a: assert property ($onehot0(~digit_sel_n))
    else $error("more than one digit selected");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");

  conv_seen_c: cover property (convert_en);
  blank_rise_c: cover property ($rose(display_blank));
  blank_fall_c: cover property ($fell(display_blank));
endmodule

bind ctf_top ctf_top_assertions i_ctf_top_assertions (.hclk, .hresetn,
  .hreadyout, .hresp, .pin_ctrl, .speed_binary, .convert_en,
  .display_blank, .segments, .digit_sel_n);

// [test/ctf_sensor_model.sv]
// optical sensor pair and decimal converter beside the controller
`timescale 1ns/1ps
module ctf_sensor_model
  import ctf_pkg::*;
(
  input wire logic hclk,
  input wire logic fire,
  input wire logic [15:0] gap,
  input wire logic [13:0] speed_binary,
  input wire logic convert_en,
  output logic start_in,
  output logic stop_in,
  output ctf_bcd_t bcd_digits
);
  initial
  begin
    start_in = 1'b0;
    stop_in = 1'b0;
    bcd_digits = '0;
  end

  // beams break for 4 clocks so a slow sync still sees them
  always @(posedge fire)
  begin
    start_in <= 1'b1;
    repeat (4) @(posedge hclk);
    start_in <= 1'b0;
    repeat (gap - 16'd4) @(posedge hclk);
    stop_in <= 1'b1;
    repeat (4) @(posedge hclk);
    stop_in <= 1'b0;
  end

  // converter answers one clock after its enable
  always @(posedge hclk)
  begin
    if (convert_en)
    begin
      bcd_digits.top_decimal_digit <= speed_binary >= 14'd10000;
      bcd_digits.thousands <= 4'((speed_binary / 1000) % 10);
      bcd_digits.hundreds <= 4'((speed_binary / 100) % 10);
      bcd_digits.tens <= 4'((speed_binary / 10) % 10);
      bcd_digits.ones <= 4'(speed_binary % 10);
    end
  end
endmodule

// [test/test_chronograph_timing_fsm.sv]
// measurement runs checked through bus reads and ports
`timescale 1ns/1ps
module test_chronograph_timing_fsm
  import ctf_pkg::*;
;
  // slow oscillator figure keeps the subtraction loop short
  localparam longint OHZ = 1_000_000;
  localparam longint DIST = OHZ * SPACING_MM * DIST_SCALE / 1000;
  localparam longint MINT = DIST / SPEED_MAX_DM;
  logic hclk, hresetn, hsel, hwrite, hready, fire;
  logic hreadyout, hresp, start_in, stop_in, convert_en, display_blank;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] gap;
  logic [13:0] speed_binary;
  logic [7:0] segments;
  logic [3:0] digit_sel_n;
  ctf_bcd_t bcd_digits;
  ctf_pins_t pin_ctrl;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  assign hready = hreadyout;

  // short stop limit lets the abandon path run within the budget
  ctf_top #(.INIT_TICKS(32'd20), .BLANK_TICKS(32'd50),
    .HOLD_TICKS(32'd30), .OSC_HZ(OHZ), .SCAN_TICKS(4),
    .STOP_LIMIT(24'd4000)) i_ctf_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .start_in(start_in), .stop_in(stop_in),
    .bcd_digits(bcd_digits), .pin_ctrl(pin_ctrl),
    .speed_binary(speed_binary), .convert_en(convert_en),
    .display_blank(display_blank), .segments(segments),
    .digit_sel_n(digit_sel_n));
  ctf_sensor_model i_ctf_sensor_model (.hclk(hclk), .fire(fire),
    .gap(gap), .speed_binary(speed_binary), .convert_en(convert_en),
    .start_in(start_in), .stop_in(stop_in), .bcd_digits(bcd_digits));

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single transfer; entered right after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, wd,
    output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  function automatic logic [13:0] exp_speed(input longint e);
    longint q;
    q = (e < MINT) ? DIST / 24'hffffff : DIST / e;
    return (q > 16383) ? SPEED_SAT : 14'(q);
  endfunction

  task automatic measure(input int g);
    int t0;
    logic [31:0] e, ee;
    // both beams see the same sync delay, so the count is the gap less one
    ee = (g - 1 < MINT) ? 32'hffffff : 32'(g - 1);
    gap <= 16'(g);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    t0 = cyc;
    while (convert_en !== 1'b1 && cyc - t0 < 20000) @(posedge hclk);
    t0 = cyc;
    check("convert", convert_en, 1'b1);
    bus(0, ADDR_ELAPSED, 0, e);
    check("elapsed", e, ee);
    check("speed", speed_binary, exp_speed(ee));
    bus(0, ADDR_SPEED, 0, rd);
    check("speed reg", rd, 32'(exp_speed(ee)));
    while (display_blank !== 1'b1 && cyc - t0 < 500) @(posedge hclk);
    check("blank delay", cyc - t0 inside {[78:88]}, 1'b1);
    bus(0, ADDR_STATUS, 0, rd);
    check("idle", rd[7:0], 8'h82);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = '0;
    fire = 1'b0;
    gap = 16'd100;
    void'($urandom(32'h136f));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, ADDR_STATUS, 0, rd);
    check("init", rd[7:0], 8'h81);
    bus(0, ADDR_CTRL, 0, rd);
    check("ctrl", rd, 32'h1);
    bus(0, 32'h10, 0, rd);
    check("unmapped", rd, 32'h0);
    // a write outside the map must not reach the control word
    bus(1, 32'h10, 0, rd);
    bus(0, ADDR_CTRL, 0, rd);
    check("alias", rd, 32'h1);
    // settling ends at the twentieth active edge after release
    repeat (8) @(posedge hclk);
    bus(0, ADDR_STATUS, 0, rd);
    check("init end", rd[7:0], 8'h81);
    bus(0, ADDR_STATUS, 0, rd);
    check("idle", rd[7:0], 8'h82);
    // disarmed: a full sensor pass must be ignored
    bus(1, ADDR_CTRL, 0, rd);
    beams(100, 120);
    bus(0, ADDR_STATUS, 0, rd);
    check("disarmed", rd[7:0], 8'h82);
    bus(1, ADDR_CTRL, 1, rd);
    measure(199);
    measure(200);
    measure(150);
    measure(250);
    measure(1000);
    repeat (3) measure($urandom_range(3000, 400));
    // no stop inside the limit: dropped, flag sticks, late stop ignored
    beams(5000, 5100);
    bus(0, ADDR_STATUS, 0, rd);
    check("abandon", rd[8:0], 9'h182);
    bus(1, ADDR_STATUS, 32'h100, rd);
    bus(0, ADDR_STATUS, 0, rd);
    check("abandon clr", rd[8:0], 9'h082);
    // reset in mid-run brings back initialisation and the arm default
    bus(1, ADDR_CTRL, 0, rd);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, ADDR_STATUS, 0, rd);
    check("reinit", rd[8:0], 9'h081);
    bus(0, ADDR_CTRL, 0, rd);
    check("rearm", rd, 32'h1);
    end_sim();
  end

  // one beam pass with a chosen gap, then a fixed wait
  task automatic beams(input int g, input int w);
    gap <= 16'(g);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (w) @(posedge hclk);
  endtask
endmodule
